// [hdl/lpsc_led_pattern_sequencer_ctrl.sv]
// Pattern sequencer for four LED current sources with its five control registers.
// Assumes an I2C slave on the same clock issues one-cycle register writes and reads.
module lpsc_led_pattern_sequencer_ctrl
  import lpsc_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port from the I2C slave
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Trigger pin from GPIO/audio input, asynchronous
  input wire logic gpioTrigger,
  // Current source enables
  output logic [3:0] ledOutput,
  output logic patternActive
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] timing_reg;
  logic [7:0] pulse_reg;
  logic [7:0] skip_reg;
  logic [7:0] lag_reg;
  logic phaseOut_reg;
  logic runBit_reg;
  logic startSrc_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Software writes; the run bit is write-only and only held internally.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      timing_reg <= TIMING_RESET;
      pulse_reg <= ZERO_RESET;
      skip_reg <= ZERO_RESET;
      lag_reg <= ZERO_RESET;
      phaseOut_reg <= 1'b0;
      runBit_reg <= 1'b0;
      startSrc_reg <= SRC_RESET;
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        ADDR_TIMING: timing_reg <= regWdata;
        ADDR_PULSE: pulse_reg <= regWdata;
        ADDR_SKIP: skip_reg <= regWdata;
        ADDR_LAG: lag_reg <= regWdata;
        ADDR_START:
        begin
          phaseOut_reg <= regWdata[PHASE_OUT_BIT];
          runBit_reg <= regWdata[RUN_BIT];
          startSrc_reg <= regWdata[SRC_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Read data; reserved bits read zero and the run bit reads zero because it is write-only.
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (regAddr)
      ADDR_TIMING: rdata_next = {2'b00, timing_reg[OFF_MSB:ON_LSB]};
      ADDR_PULSE: rdata_next = {pulse_reg[PULSE_MSB:PULSE_LSB], 4'h0, pulse_reg[GAP_MSB:GAP_LSB]};
      ADDR_SKIP: rdata_next = skip_reg;
      ADDR_LAG: rdata_next = lag_reg;
      ADDR_START:
      begin
        rdata_next[PHASE_OUT_BIT] = phaseOut_reg;
        rdata_next[SRC_BIT] = startSrc_reg;
        rdata_next[ACTIVE_BIT] = patternActive;
      end
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else if (regRead)
      rdata_reg <= rdata_next;
  end
  assign regRdata = rdata_reg;

  // ****************************************************************
  // Trigger selection
  // ****************************************************************
  logic gpioMeta_reg;
  logic gpioSync_reg;
  logic runReq;

  // Two-stage synchroniser for the pin; only the second stage is used.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      gpioMeta_reg <= 1'b0;
      gpioSync_reg <= 1'b0;
    end
    else
    begin
      gpioMeta_reg <= gpioTrigger;
      gpioSync_reg <= gpioMeta_reg;
    end
  end

  // The trigger source picks the software bit or the pin level.
  assign runReq = startSrc_reg ? gpioSync_reg : runBit_reg;

  // ****************************************************************
  // Millisecond tick and phase timer
  // ****************************************************************
  lpsc_state_t state_reg;
  lpsc_state_t state_next;
  logic [31:0] tickCnt_reg;
  logic tick;
  lpsc_ms_t msCnt_reg;
  lpsc_ms_t phaseTarget;
  logic phaseDone;
  logic phaseChange;

  // A finished on phase always restarts the timer, even when a zero pause keeps the state at on.
  assign phaseChange = (state_next != state_reg) || (state_reg == ST_ON && phaseDone);
  assign tick = (tickCnt_reg == 32'(TICK_CYCLES_P - 1));

  // The prescaler restarts with each phase so every phase gets its full length.
  always_ff @(posedge clock)
  begin
    if (rst || phaseChange || tick)
      tickCnt_reg <= 32'h0000_0000;
    else
      tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge clock)
  begin
    if (rst || phaseChange)
      msCnt_reg <= '0;
    else if (tick)
      msCnt_reg <= msCnt_reg + 14'd1;
  end

  // Durations are read live, so a code change affects the next phase boundary.
  always_comb
  begin
    phaseTarget = '0;
    unique case (state_reg)
      ST_ON: phaseTarget = onMs(timing_reg[ON_MSB:ON_LSB]);
      ST_GAP: phaseTarget = gapMs(pulse_reg[GAP_MSB:GAP_LSB]);
      ST_OFF: phaseTarget = offMs(timing_reg[OFF_MSB:OFF_LSB]);
      default: phaseTarget = '0;
    endcase
  end
  assign phaseDone = (msCnt_reg >= phaseTarget);

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  logic [1:0] pulseIdx_reg;
  logic [2:0] frameCnt_reg;
  logic [7:0] lagLatch_reg;
  logic lastPulse;
  logic frameEnd;
  logic startNow;

  assign lastPulse = (pulseIdx_reg == pulse_reg[PULSE_MSB:PULSE_LSB]);
  assign frameEnd = (state_reg == ST_OFF) && phaseDone;
  assign startNow = (state_reg == ST_IDLE) && runReq;

  // On time, pauses and repeats, then off time; a zero pause goes straight to the next pulse.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (runReq)
          state_next = ST_ON;
      ST_ON:
        if (!runReq && !phaseOut_reg)
          state_next = ST_IDLE;
        else if (phaseDone && lastPulse)
          state_next = ST_OFF;
        else if (phaseDone && gapMs(pulse_reg[GAP_MSB:GAP_LSB]) == '0)
          state_next = ST_ON;
        else if (phaseDone)
          state_next = ST_GAP;
      ST_GAP:
        if (!runReq && !phaseOut_reg)
          state_next = ST_IDLE;
        else if (phaseDone)
          state_next = ST_ON;
      ST_OFF:
        if (!runReq && !phaseOut_reg)
          state_next = ST_IDLE;
        else if (phaseDone && !runReq)
          state_next = ST_IDLE;
        else if (phaseDone)
          state_next = ST_ON;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Pulse index steps on each pulse end but the last and clears at the frame boundary.
  always_ff @(posedge clock)
  begin
    if (rst || state_reg == ST_IDLE || frameEnd)
      pulseIdx_reg <= 2'b00;
    else if (state_reg == ST_ON && phaseDone && !lastPulse)
      pulseIdx_reg <= pulseIdx_reg + 2'b01;
  end

  // Frames since start; saturates at seven, above the largest lag plus mask of six.
  always_ff @(posedge clock)
  begin
    if (rst || startNow)
      frameCnt_reg <= 3'b000;
    else if (frameEnd && frameCnt_reg != 3'b111)
      frameCnt_reg <= frameCnt_reg + 3'b001;
  end

  // Start lags are taken only when the pattern leaves idle, so edits wait for a restart.
  always_ff @(posedge clock)
  begin
    if (rst)
      lagLatch_reg <= ZERO_RESET;
    else if (startNow)
      lagLatch_reg <= lag_reg;
  end

  // ****************************************************************
  // Per-source output gating
  // ****************************************************************
  logic [3:0] ledOut_reg;
  logic active_reg;

  // Each source waits its lag, then its masked frames, before it may light.
  for (genvar i = 0; i < 4; i++)
  begin : gSrc
    logic [2:0] firstFrame;
    assign firstFrame = {1'b0, lagLatch_reg[2*i+1 -: 2]} + {1'b0, skip_reg[2*i+1 -: 2]};
    always_ff @(posedge clock)
    begin
      if (rst)
        ledOut_reg[i] <= 1'b0;
      else
        ledOut_reg[i] <= (state_reg == ST_ON) && (frameCnt_reg >= firstFrame);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      active_reg <= 1'b0;
    else
      active_reg <= (state_reg != ST_IDLE);
  end

  assign ledOutput = ledOut_reg;
  assign patternActive = active_reg;

endmodule : lpsc_led_pattern_sequencer_ctrl

// [include/lpsc_pkg.sv]
// Constants, code tables and state encoding for the LED pattern sequencer.
// Assumes a 50 MHz system clock and a register port driven by an I2C slave on that clock.
//
// Operation
// - Off-time code selects one shared off duration.
// - On-time code selects one shared on duration.
// - Pulse-count code gives one to four pulses.
// - Pause code sets gap between repeated pulses.
// - Per-source mask hides zero to three frames.
// - Run cleared without phase-out stops at once.
// - Run bit written one starts, zero stops.
// - Trigger bit picks run bit or pin; resets one.
// - Per-source start delay of zero to three frames.
// - Start delays latched only at pattern restart.
package lpsc_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam logic [7:0] ADDR_TIMING = 8'h18;
  localparam logic [7:0] ADDR_PULSE = 8'h19;
  localparam logic [7:0] ADDR_SKIP = 8'h1A;
  localparam logic [7:0] ADDR_START = 8'h1B;
  localparam logic [7:0] ADDR_LAG = 8'h1C;
  localparam int OFF_MSB = 5;
  localparam int OFF_LSB = 3;
  localparam int ON_MSB = 2;
  localparam int ON_LSB = 0;
  localparam int PULSE_MSB = 7;
  localparam int PULSE_LSB = 6;
  localparam int GAP_MSB = 1;
  localparam int GAP_LSB = 0;
  localparam int PHASE_OUT_BIT = 2;
  localparam int RUN_BIT = 1;
  localparam int SRC_BIT = 0;
  localparam int ACTIVE_BIT = 3;
  localparam logic [7:0] TIMING_RESET = 8'h18;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam logic SRC_RESET = 1'b1;

  // ****************************************************************
  // Time base: all durations are counted in millisecond ticks
  // ****************************************************************
  localparam int CLOCK_HZ = 50000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
  localparam int MSW = 14;
  typedef logic [MSW-1:0] lpsc_ms_t;

  // ****************************************************************
  // State encoding
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ON = 4'h2,
    ST_GAP = 4'h4,
    ST_OFF = 4'h8
  } lpsc_state_t;

  // Off time in milliseconds per code.
  function automatic lpsc_ms_t offMs(input logic [2:0] code);
    unique case (code)
      3'h0: offMs = 14'd80;
      3'h1: offMs = 14'd150;
      3'h2: offMs = 14'd280;
      3'h3: offMs = 14'd540;
      3'h4: offMs = 14'd1100;
      3'h5: offMs = 14'd2100;
      3'h6: offMs = 14'd4200;
      3'h7: offMs = 14'd8400;
    endcase
  endfunction : offMs

  // On time in milliseconds per code.
  function automatic lpsc_ms_t onMs(input logic [2:0] code);
    unique case (code)
      3'h0: onMs = 14'd40;
      3'h1: onMs = 14'd70;
      3'h2: onMs = 14'd140;
      3'h3: onMs = 14'd270;
      3'h4: onMs = 14'd530;
      3'h5: onMs = 14'd1100;
      3'h6: onMs = 14'd2100;
      3'h7: onMs = 14'd4200;
    endcase
  endfunction : onMs

  // Pause between pulses in milliseconds per code.
  function automatic lpsc_ms_t gapMs(input logic [1:0] code);
    unique case (code)
      2'h0: gapMs = 14'd0;
      2'h1: gapMs = 14'd150;
      2'h2: gapMs = 14'd280;
      2'h3: gapMs = 14'd540;
    endcase
  endfunction : gapMs

endpackage : lpsc_pkg

// [tb/lpsc_checker_sva.sv]
// Port assertions for the LED pattern sequencer.
// Assumes it is bound to the sequencer top module.
module lpsc_checker
  import lpsc_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port and pin
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic gpioTrigger,
  // Source enables
  input wire logic [3:0] ledOutput,
  input wire logic patternActive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ctlWr;
  logic srcReg;
  logic [7:0] timeReg;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Shadow copies, because the checker cannot see the register bodies.
  assign ctlWr = regWrite && regAddr == ADDR_START;
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      srcReg <= SRC_RESET;
      timeReg <= TIMING_RESET;
    end
    else
    begin
      if (ctlWr)
        srcReg <= regWdata[SRC_BIT];
      if (regWrite && regAddr == ADDR_TIMING)
        timeReg <= regWdata;
    end
  end
  a_run_starts: assert property (ctlWr && regWdata[2:0] == 3'h2 && !patternActive |-> ##3 patternActive)
    else $error("run write did not start");
  a_stop_now: assert property (ctlWr && regWdata[2:0] == 3'h0 |-> ##3 !patternActive && ledOutput == 4'h0)
    else $error("stop was not immediate");
  a_phase_out: assert property (ctlWr && regWdata[2:0] == 3'h4 && ledOutput != 4'h0 |-> ##3 patternActive)
    else $error("phase-out stopped at once");
  a_unmapped_zero: assert property (regRead && (regAddr < ADDR_TIMING || regAddr > ADDR_LAG) |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!regRead |=> $stable(regRdata))
    else $error("read data moved");
  a_timing_back: assert property (regRead && regAddr == ADDR_TIMING |=> regRdata == {2'b00, timeReg[5:0]})
    else $error("timing readback wrong");
  a_source_back: assert property (regRead && regAddr == ADDR_START |=> regRdata[1:0] == {1'b0, srcReg})
    else $error("start control readback wrong");
  a_pin_start: assert property (srcReg && !patternActive && gpioTrigger ##1 gpioTrigger [*5] |-> patternActive)
    else $error("pin did not start");
  a_led_active: assert property (ledOutput != 4'h0 |-> patternActive)
    else $error("source lit while idle");
  a_on_minimum: assert property ($rose(patternActive) ##0 (!regWrite) [*8] |-> patternActive)
    else $error("pattern ended too soon");
endmodule : lpsc_checker

bind lpsc_led_pattern_sequencer_ctrl lpsc_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk (.clock(clock), .rst(rst),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .gpioTrigger(gpioTrigger), .ledOutput(ledOutput), .patternActive(patternActive));

// [tb/lpsc_led_sources.sv]
// Model of the four LED current sources.
// Assumes active-high enables sampled on the system clock.
module lpsc_led_sources
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Source enables
  input wire logic [3:0] ledOutput,
  // Switch-on count of source one
  output int riseCount
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;
  // Count switch-ons, so a stray pulse after a stop is caught.
  always_ff @(posedge clock)
  begin
    last <= ledOutput[0];
    if (rst)
      riseCount <= 0;
    else if (ledOutput[0] && !last)
      riseCount <= riseCount + 1;
  end
endmodule : lpsc_led_sources

// [tb/lpsc_led_pattern_sequencer_ctrl_bench.sv]
// Self-checking bench for the LED pattern sequencer.
// Assumes a 2-cycle tick so long durations stay short.
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin nMismatch++; $display("[ERR] %0t mismatch", $time); end end
module lpsc_led_pattern_sequencer_ctrl_bench import lpsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 2;
  int onT[8] = '{40, 70, 140, 270, 530, 1100, 2100, 4200};
  int offT[8] = '{80, 150, 280, 540, 1100, 2100, 4200, 8400};
  int gapT[4] = '{0, 150, 280, 540};
  int nMismatch = 0;
  int checksDone = 0;
  int hi, lo, rc, riseCount;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic gpioTrigger = 1'b0;
  logic [7:0] v;
  logic [7:0] regRdata;
  logic [3:0] ledOutput;
  logic patternActive;
  // ****
  // Clock, design and source model
  // ****
  always #10 clock = ~clock;
  lpsc_led_pattern_sequencer_ctrl #(.TICK_CYCLES_P(TK)) dut (.clock(clock), .rst(rst), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .gpioTrigger(gpioTrigger),
    .ledOutput(ledOutput), .patternActive(patternActive));
  lpsc_led_sources src (.clock(clock), .rst(rst), .ledOutput(ledOutput), .riseCount(riseCount));
  // A trailing idle cycle keeps two strobes from landing in one time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
    @(negedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    @(negedge clock);
    v = regRdata;
  endtask : rd
  // Counts cycles until source one shows level s, bounded.
  task automatic span(input logic s, output int n);
    n = 0;
    while (ledOutput[0] !== s && n < 20000)
    begin
      @(negedge clock);
      n++;
    end
  endtask : span
  function automatic bit near(int g, int e);
    near = g >= e - 3 && g <= e + 3;
  endfunction : near
  function automatic logic [3:0] lit(int k, logic [7:0] g);
    for (int i = 0; i < 4; i++)
      lit[i] = k >= (((8'h04 >> (2 * i)) & 3) + g[2*i+:2]);
  endfunction : lit
  task automatic frames(input int k0, input int k1, input logic [7:0] g);
    for (int k = k0; k <= k1; k++)
    begin
      span(1'b1, rc);
      `CHK(ledOutput, lit(k, g))
      span(1'b0, hi);
    end
  endtask : frames
  task automatic tRegs();
    rd(ADDR_TIMING);
    `CHK(v, 8'h18)
    rd(ADDR_START);
    `CHK(v, 8'h01)
    rd(8'h1D);
    `CHK(v, 8'h00)
    wr(ADDR_PULSE, 8'hFF);
    rd(ADDR_PULSE);
    `CHK(v, 8'hC3)
    wr(ADDR_PULSE, 8'h00);
  endtask : tRegs
  task automatic tTiming();
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_TIMING, {2'b00, i[2:0], i[2:0]});
      wr(ADDR_START, 8'h02);
      span(1'b1, rc);
      span(1'b0, hi);
      span(1'b1, lo);
      wr(ADDR_START, 8'h00);
      `CHK(near(hi, onT[i] * TK + 1), 1'b1)
      `CHK(near(lo, offT[i] * TK + 1), 1'b1)
    end
  endtask : tTiming
  task automatic tPulses();
    wr(ADDR_TIMING, 8'h00);
    for (int c = 1; c < 4; c++)
    begin
      wr(ADDR_PULSE, {c[1:0], 4'h0, c[1:0]});
      wr(ADDR_START, 8'h02);
      span(1'b1, rc);
      for (int k = 0; k < c; k++)
      begin
        span(1'b0, hi);
        span(1'b1, lo);
        `CHK(near(hi, onT[0] * TK + 1), 1'b1)
        `CHK(near(lo, gapT[c] * TK + 1), 1'b1)
      end
      span(1'b0, hi);
      span(1'b1, lo);
      `CHK(near(lo, offT[0] * TK + 1), 1'b1)
      wr(ADDR_START, 8'h00);
    end
    wr(ADDR_PULSE, 8'h40);
    wr(ADDR_START, 8'h02);
    span(1'b1, rc);
    span(1'b0, hi);
    `CHK(near(hi, 2 * (onT[0] * TK + 1)), 1'b1)
    wr(ADDR_START, 8'h00);
    wr(ADDR_PULSE, 8'h00);
  endtask : tPulses
  // New lags written mid-run must wait for the restart.
  task automatic tMask();
    wr(ADDR_SKIP, 8'h04);
    wr(ADDR_START, 8'h02);
    frames(0, 1, 8'h00);
    wr(ADDR_LAG, 8'hE0);
    frames(2, 3, 8'h00);
    wr(ADDR_START, 8'h00);
    wr(ADDR_START, 8'h02);
    frames(0, 3, 8'hE0);
    wr(ADDR_START, 8'h00);
    wr(ADDR_SKIP, 8'h00);
    wr(ADDR_LAG, 8'h00);
  endtask : tMask
  task automatic tStop();
    wr(ADDR_START, 8'h02);
    span(1'b1, rc);
    wr(ADDR_START, 8'h00);
    rc = riseCount;
    @(negedge clock);
    `CHK(patternActive, 1'b0)
    repeat (400) @(negedge clock);
    `CHK(riseCount, rc)
    wr(ADDR_START, 8'h06);
    span(1'b1, rc);
    wr(ADDR_START, 8'h04);
    @(negedge clock);
    `CHK(patternActive, 1'b1)
    span(1'b0, hi);
    lo = 0;
    while (patternActive === 1'b1 && lo < 2000)
    begin
      @(negedge clock);
      lo++;
    end
    rc = riseCount;
    repeat (400) @(negedge clock);
    `CHK(near(lo, offT[0] * TK + 1), 1'b1)
    `CHK(riseCount, rc)
  endtask : tStop
  task automatic tPin();
    wr(ADDR_START, 8'h01);
    gpioTrigger = 1'b1;
    repeat (8) @(negedge clock);
    `CHK(patternActive, 1'b1)
    gpioTrigger = 1'b0;
    repeat (8) @(negedge clock);
    `CHK(patternActive, 1'b0)
    wr(ADDR_START, 8'h00);
    gpioTrigger = 1'b1;
    repeat (8) @(negedge clock);
    `CHK(patternActive, 1'b0)
    gpioTrigger = 1'b0;
  endtask : tPin
  task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : endSim
  // Watchdog sized well above the roughly 60000 cycles the tests need.
  initial
  begin
    repeat (100000) @(posedge clock);
    nMismatch++;
    endSim();
  end
  initial
  begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    tRegs();
    tTiming();
    tPulses();
    tMask();
    tStop();
    tPin();
    endSim();
  end
endmodule : lpsc_led_pattern_sequencer_ctrl_bench
